// [design/ssp_pkg.sv]
// Constants and types shared by the sensor SPI slave port
// Summary of operation
// - Protocol pin low selects SPI, high disables it
// - Modes 0 and 3, clock level at select
// - Reset to 4-wire; 3-wire needs both bits
// - 3-wire uses the data input line both ways
// - Single-byte access is one 16-bit frame
// - Master owns clock; select low bounds transaction
// - Drive on falling edge, sample on rising
// - 4-wire write keeps data output released
// - First bit: zero write, one read
// - Bits one to seven: address, MSB first
// - Bits eight to fifteen carry data byte
// - Burst read auto-increments address while selected
// - Three selects; accel/mag and gyro outputs
package ssp_pkg;

  // Clock and link timing
  localparam int unsigned CLK_NS          = 8;
  localparam int unsigned IDLE_NM_NS      = 2000;
  localparam int unsigned IDLE_SUS_NS     = 450000;
  localparam int unsigned IDLE_NM_CYC     = (IDLE_NM_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned IDLE_SUS_CYC_DEF = (IDLE_SUS_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned GAP_W           = 20;

  // Frame layout
  localparam int unsigned ADDR_W   = 7;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned UNIT_W   = 2;
  localparam int unsigned WORD_W   = UNIT_W + ADDR_W + DATA_W;
  localparam int unsigned REG_NUM  = 128;
  localparam int unsigned UNIT_NUM = 3;
  localparam logic [2:0]  BIT_FIRST = 3'h0;
  localparam logic [2:0]  BIT_LAST  = 3'h7;
  localparam logic        RW_READ   = 1'b1;

  // Write word fields
  localparam int unsigned WRD_DATA_LSB = 0;
  localparam int unsigned WRD_ADDR_LSB = DATA_W;
  localparam int unsigned WRD_UNIT_LSB = DATA_W + ADDR_W;

  // Sensor units, also chip-select index
  localparam logic [1:0] UNIT_ACC = 2'h0;
  localparam logic [1:0] UNIT_GYR = 2'h1;
  localparam logic [1:0] UNIT_MAG = 2'h2;

  // 3-wire select location
  localparam logic [6:0] THREE_WIRE_SELECT_ADDR = 7'h34;
  localparam int unsigned THREE_WIRE_SELECT_BIT = 0;

  // Frame phases
  typedef enum logic [1:0] {PH_CMD, PH_DATA, PH_DONE} ssp_phase_t;

endpackage : ssp_pkg

// [design/ssp_skid.sv]
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module ssp_skid #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  output logic      [W-1:0] out_data_o,
  input  wire logic         out_ready_i
);

  logic         out_v_q, out_v_d;
  logic [W-1:0] out_q, out_d;
  logic         sp_v_q, sp_v_d;
  logic [W-1:0] sp_q, sp_d;
  logic         take;

  // Output slot refills from spare first to keep order
  always_comb begin
    out_v_d = out_v_q;
    out_d   = out_q;
    sp_v_d  = sp_v_q;
    sp_d    = sp_q;
    take    = in_valid_i & ~sp_v_q;
    if (!out_v_q || out_ready_i) begin
      if (sp_v_q) begin
        out_v_d = 1'b1;
        out_d   = sp_q;
        sp_v_d  = take;
        sp_d    = in_data_i;
      end else begin
        out_v_d = in_valid_i;
        out_d   = in_data_i;
      end
    end else if (take) begin
      sp_v_d = 1'b1;
      sp_d   = in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_v_q <= 1'b0;
      out_q   <= '0;
      sp_v_q  <= 1'b0;
      sp_q    <= '0;
    end else begin
      out_v_q <= out_v_d;
      out_q   <= out_d;
      sp_v_q  <= sp_v_d;
      sp_q    <= sp_d;
    end
  end

  // Ready is registered: full exactly when spare holds a word
  assign in_ready_o  = ~sp_v_q;
  assign out_valid_o = out_v_q;
  assign out_data_o  = out_q;

endmodule : ssp_skid

// [design/ssp_slave_port.sv]
// SPI slave port for three sensor units with register mirror
`timescale 1ns/1ps
module ssp_slave_port
  import ssp_pkg::*;
#(
  parameter int unsigned IDLE_SUS_CYC = IDLE_SUS_CYC_DEF
) (
  input  wire logic              mclk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              protocol_select_pin_i,
  input  wire logic              sck_i,
  input  wire logic [2:0]        sensor_select_n_i,
  input  wire logic              shared_data_pin_i,
  output logic                   shared_data_pin_o,
  output logic                   shared_data_pin_oe_o,
  output logic                   sdo_am_o,
  output logic                   sdo_am_oe_o,
  output logic                   sdo_gyr_o,
  output logic                   sdo_gyr_oe_o,
  input  wire logic              suspend_mode_i,
  output logic                   wr_valid_o,
  output logic [UNIT_W-1:0]      wr_unit_o,
  output logic [ADDR_W-1:0]      wr_addr_o,
  output logic [DATA_W-1:0]      wr_data_o,
  input  wire logic              wr_ready_i,
  output logic                   spi_enabled_o,
  output logic                   three_wire_o,
  output logic                   clock_mode_o,
  output logic                   write_gap_err_o,
  output logic                   write_lost_o
);

  // ------------------------------------------------------------------
  // Link domain (sck_i); frame state cleared while all selects are high
  // ------------------------------------------------------------------
  logic              frame_idle;
  logic [1:0]        cfg_m_q;
  logic [1:0]        cfg_s_q;
  logic              spi_en_q;
  logic              three_wire_q;
  ssp_phase_t        ph_q, ph_d;
  logic [2:0]        bcnt_q, bcnt_d;
  logic              rw_q, rw_d;
  logic [UNIT_W-1:0] unit_q, unit_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] sh_q, sh_d;
  logic [UNIT_W-1:0] sel_unit;
  logic              commit;
  logic [WORD_W-1:0] wword_q, wword_d;
  logic              wtog_q, wtog_d;
  logic [DATA_W-1:0] regmem_q [UNIT_NUM][REG_NUM];
  logic [DATA_W-1:0] osh_q, osh_d;
  logic              obit_q, obit_d;
  logic              oe_am_q, oe_am_d;
  logic              oe_gyr_q, oe_gyr_d;
  logic              oe_sh_q, oe_sh_d;
  logic              drive;

  // A transaction lives only while some select is low
  assign frame_idle = &sensor_select_n_i;

  // Lowest select wins if a master wrongly lowers two
  always_comb begin
    if (!sensor_select_n_i[UNIT_ACC]) begin
      sel_unit = UNIT_ACC;
    end else if (!sensor_select_n_i[UNIT_GYR]) begin
      sel_unit = UNIT_GYR;
    end else begin
      sel_unit = UNIT_MAG;
    end
  end

  // Config levels crossing into the link domain
  always_ff @(posedge sck_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_m_q <= 2'h0;
      cfg_s_q <= 2'h0;
    end else begin
      cfg_m_q <= {three_wire_q, spi_en_q};
      cfg_s_q <= cfg_m_q;
    end
  end

  // Frame decode on rising edges: direction, address, data
  always_comb begin
    ph_d   = ph_q;
    bcnt_d = bcnt_q + 3'h1;
    rw_d   = rw_q;
    unit_d = unit_q;
    addr_d = addr_q;
    sh_d   = {sh_q[DATA_W-2:0], shared_data_pin_i};
    commit = 1'b0;
    case (ph_q)
      PH_CMD: begin
        if (bcnt_q == BIT_FIRST) begin
          rw_d   = shared_data_pin_i;
          unit_d = sel_unit;
        end else begin
          addr_d = {addr_q[ADDR_W-2:0], shared_data_pin_i};
        end
        if (bcnt_q == BIT_LAST) begin
          ph_d = PH_DATA;
        end
      end
      PH_DATA: begin
        if (bcnt_q == BIT_LAST) begin
          if (rw_q == RW_READ) begin
            addr_d = addr_q + 7'h01;
          end else begin
            commit = cfg_s_q[0];
            ph_d   = PH_DONE;
          end
        end
      end
      default: begin
        // Extra clocks after a write are ignored
        ph_d = PH_DONE;
      end
    endcase
  end

  always_ff @(posedge sck_i or posedge frame_idle) begin
    if (frame_idle) begin
      ph_q   <= PH_CMD;
      bcnt_q <= 3'h0;
      rw_q   <= 1'b0;
      unit_q <= UNIT_ACC;
      addr_q <= 7'h00;
      sh_q   <= 8'h00;
    end else begin
      ph_q   <= ph_d;
      bcnt_q <= bcnt_d;
      rw_q   <= rw_d;
      unit_q <= unit_d;
      addr_q <= addr_d;
      sh_q   <= sh_d;
    end
  end

  // Completed write word and its event toggle persist across frames
  always_comb begin
    wword_d = wword_q;
    wtog_d  = wtog_q;
    if (commit) begin
      wword_d = {unit_q, addr_q, sh_q[DATA_W-2:0], shared_data_pin_i};
      wtog_d  = ~wtog_q;
    end
  end

  always_ff @(posedge sck_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wword_q <= '0;
      wtog_q  <= 1'b0;
    end else begin
      wword_q <= wword_d;
      wtog_q  <= wtog_d;
    end
  end

  // Register mirror; no reset, contents are software-defined
  always_ff @(posedge sck_i) begin
    if (commit) begin
      regmem_q[unit_q][addr_q] <= {sh_q[DATA_W-2:0], shared_data_pin_i};
    end
  end

  // Read data leaves on falling edges, only in the data phase
  assign drive = (ph_q == PH_DATA) && (rw_q == RW_READ) && cfg_s_q[0];

  always_comb begin
    osh_d    = {osh_q[DATA_W-2:0], 1'b0};
    obit_d   = osh_q[DATA_W-1];
    if ((ph_q == PH_DATA) && (bcnt_q == BIT_FIRST)) begin
      osh_d  = regmem_q[unit_q][addr_q];
      obit_d = osh_d[DATA_W-1];
      osh_d  = {osh_d[DATA_W-2:0], 1'b0};
    end
    oe_am_d  = drive && !cfg_s_q[1] && (unit_q != UNIT_GYR);
    oe_gyr_d = drive && !cfg_s_q[1] && (unit_q == UNIT_GYR);
    oe_sh_d  = drive && cfg_s_q[1];
  end

  // Falling edge drives; rising select releases every pin at once
  always_ff @(negedge sck_i or posedge frame_idle) begin
    if (frame_idle) begin
      osh_q    <= 8'h00;
      obit_q   <= 1'b0;
      oe_am_q  <= 1'b0;
      oe_gyr_q <= 1'b0;
      oe_sh_q  <= 1'b0;
    end else begin
      osh_q    <= osh_d;
      obit_q   <= obit_d;
      oe_am_q  <= oe_am_d;
      oe_gyr_q <= oe_gyr_d;
      oe_sh_q  <= oe_sh_d;
    end
  end

  assign shared_data_pin_o    = obit_q;
  assign shared_data_pin_oe_o = oe_sh_q;
  assign sdo_am_o             = obit_q;
  assign sdo_am_oe_o          = oe_am_q;
  assign sdo_gyr_o            = obit_q;
  assign sdo_gyr_oe_o         = oe_gyr_q;

  // ------------------------------------------------------------------
  // System domain (mclk_i)
  // ------------------------------------------------------------------
  logic [5:0]        in_s;
  logic              ps_s, idle_s, sck_s, wtog_s;
  logic              spi_en_d, three_wire_d;
  logic              idle_prev_q, idle_prev_d;
  logic              mode_q, mode_d;
  logic              tog_prev_q, tog_prev_d;
  logic              pend_q, pend_d;
  logic              lost_q, lost_d;
  logic              acc3_q, acc3_d;
  logic              gyr3_q, gyr3_d;
  logic [GAP_W-1:0]  gap_q, gap_d;
  logic              gap_err_q, gap_err_d;
  logic              wr_event;
  logic              push;
  logic              buf_ready;
  logic [WORD_W-1:0] buf_out;
  logic [GAP_W-1:0]  gap_min;

  ssp_sync #(
    .W (6)
  ) u_in_sync (
    .clk_i (mclk_i),
    .rst_i (sys_rst_i),
    .d_i   ({~protocol_select_pin_i, ~sensor_select_n_i, sck_i, wtog_q}), // Reset 0 = idle
    .q_o   (in_s)
  );

  assign ps_s     = in_s[5];
  assign idle_s   = ~|in_s[4:2];
  assign sck_s    = in_s[1];
  assign wtog_s   = in_s[0];
  assign wr_event = wtog_s ^ tog_prev_q;
  assign push     = pend_q & buf_ready;
  assign gap_min  = suspend_mode_i ? GAP_W'(IDLE_SUS_CYC) : GAP_W'(IDLE_NM_CYC);

  // Mode capture, write hand-off, 3-wire bits, gap watch
  always_comb begin
    spi_en_d    = ps_s;
    idle_prev_d = idle_s;
    mode_d      = mode_q;
    if (idle_prev_q && !idle_s) begin
      mode_d = sck_s;
    end
    tog_prev_d = wtog_s;
    pend_d     = pend_q;
    if (push) begin
      pend_d = 1'b0;
    end
    if (wr_event) begin
      pend_d = 1'b1;
    end
    // Word is overwritten only if the buffer stalled a whole frame
    lost_d = lost_q | (wr_event & pend_q & ~push);
    acc3_d = acc3_q;
    gyr3_d = gyr3_q;
    if (push && (wword_q[WRD_ADDR_LSB +: ADDR_W] == THREE_WIRE_SELECT_ADDR)) begin
      if (wword_q[WRD_UNIT_LSB +: UNIT_W] == UNIT_ACC) begin
        acc3_d = wword_q[WRD_DATA_LSB + THREE_WIRE_SELECT_BIT];
      end else if (wword_q[WRD_UNIT_LSB +: UNIT_W] == UNIT_GYR) begin
        gyr3_d = wword_q[WRD_DATA_LSB + THREE_WIRE_SELECT_BIT];
      end
    end
    three_wire_d = acc3_q & gyr3_q;
    // Master-side spacing is only observed, never enforced
    gap_err_d = wr_event && (gap_q < gap_min);
    gap_d     = gap_q;
    if (wr_event) begin
      gap_d = '0;
    end else if (gap_q != {GAP_W{1'b1}}) begin
      gap_d = gap_q + 20'h00001;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      spi_en_q     <= 1'b0;
      three_wire_q <= 1'b0;
      idle_prev_q  <= 1'b1;
      mode_q       <= 1'b0;
      tog_prev_q   <= 1'b0;
      pend_q       <= 1'b0;
      lost_q       <= 1'b0;
      acc3_q       <= 1'b0;
      gyr3_q       <= 1'b0;
      gap_q        <= {GAP_W{1'b1}};
      gap_err_q    <= 1'b0;
    end else begin
      spi_en_q     <= spi_en_d;
      three_wire_q <= three_wire_d;
      idle_prev_q  <= idle_prev_d;
      mode_q       <= mode_d;
      tog_prev_q   <= tog_prev_d;
      pend_q       <= pend_d;
      lost_q       <= lost_d;
      acc3_q       <= acc3_d;
      gyr3_q       <= gyr3_d;
      gap_q        <= gap_d;
      gap_err_q    <= gap_err_d;
    end
  end

  // Completed writes toward the sensor cores, stallable
  ssp_skid #(
    .W (WORD_W)
  ) u_wr_buf (
    .clk_i       (mclk_i),
    .rst_i       (sys_rst_i),
    .in_valid_i  (pend_q),
    .in_data_i   (wword_q),
    .in_ready_o  (buf_ready),
    .out_valid_o (wr_valid_o),
    .out_data_o  (buf_out),
    .out_ready_i (wr_ready_i)
  );

  assign wr_unit_o       = buf_out[WRD_UNIT_LSB +: UNIT_W];
  assign wr_addr_o       = buf_out[WRD_ADDR_LSB +: ADDR_W];
  assign wr_data_o       = buf_out[WRD_DATA_LSB +: DATA_W];
  assign spi_enabled_o   = spi_en_q;
  assign three_wire_o    = three_wire_q;
  assign clock_mode_o    = mode_q;
  assign write_gap_err_o = gap_err_q;
  assign write_lost_o    = lost_q;

endmodule : ssp_slave_port

// [design/ssp_sync.sv]
// Two-flop level synchroniser, one per bit
`timescale 1ns/1ps
module ssp_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second stage
  genvar g;
  for (g = 0; g < W; g++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        meta_q[g] <= 1'b0;
        sync_q[g] <= 1'b0;
      end else begin
        meta_q[g] <= d_i[g];
        sync_q[g] <= meta_q[g];
      end
    end
  end

  assign q_o = sync_q;

endmodule : ssp_sync

// [sim/ssp_slave_port_assertions.sv]
// Concurrent checks on the sensor SPI slave port ports
`timescale 1ns/1ps
module ssp_slave_port_chk
  import ssp_pkg::*;
(
  input wire logic              mclk_i,
  input wire logic              sys_rst_i,
  input wire logic              protocol_select_pin_i,
  input wire logic [2:0]        sensor_select_n_i,
  input wire logic              shared_data_pin_oe_o,
  input wire logic              sdo_am_oe_o,
  input wire logic              sdo_gyr_oe_o,
  input wire logic              wr_valid_o,
  input wire logic [DATA_W-1:0] wr_data_o,
  input wire logic              wr_ready_i,
  input wire logic              spi_enabled_o,
  input wire logic              three_wire_o,
  input wire logic              write_gap_err_o,
  input wire logic              write_lost_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  // Stream and pin relations; select edges clear enables asynchronously
  word_hold_a: assert property (wr_valid_o && !wr_ready_i |=>
    wr_valid_o && $stable(wr_data_o)) else $error("write word not held");
  word_take_a: assert property ($fell(wr_valid_o) |-> $past(wr_ready_i))
    else $error("write word dropped untaken");
  idle_release_a: assert property (&sensor_select_n_i |->
    !(shared_data_pin_oe_o || sdo_am_oe_o || sdo_gyr_oe_o)) else $error("pin driven idle");
  line_4w_a: assert property (!three_wire_o |-> !shared_data_pin_oe_o)
    else $error("shared line driven in 4-wire");
  sdo_3w_a: assert property (three_wire_o |-> !sdo_am_oe_o && !sdo_gyr_oe_o)
    else $error("output pin driven in 3-wire");
  gyr_pin_a: assert property (sdo_gyr_oe_o |-> !sensor_select_n_i[1] && !sdo_am_oe_o)
    else $error("gyro output without its select");
  am_pin_a: assert property (sdo_am_oe_o |-> !(sensor_select_n_i[0] && sensor_select_n_i[2]))
    else $error("accel/mag output without select");
  strap_off_a: assert property (protocol_select_pin_i [*5] |-> !spi_enabled_o)
    else $error("port enabled with strap high");
  strap_on_a: assert property (!protocol_select_pin_i [*5] |-> spi_enabled_o)
    else $error("port disabled with strap low");
  gap_pulse_a: assert property (write_gap_err_o |=> !write_gap_err_o)
    else $error("gap flag longer than a cycle");
  lost_keep_a: assert property (write_lost_o |=> write_lost_o)
    else $error("lost flag cleared");

  // Main scenarios reached
  cover property (shared_data_pin_oe_o);
  cover property (sdo_gyr_oe_o);
  cover property (write_gap_err_o);
  cover property (write_lost_o);
endmodule : ssp_slave_port_chk

bind ssp_slave_port ssp_slave_port_chk u_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
  .protocol_select_pin_i(protocol_select_pin_i), .sensor_select_n_i(sensor_select_n_i),
  .shared_data_pin_oe_o(shared_data_pin_oe_o), .sdo_am_oe_o(sdo_am_oe_o),
  .sdo_gyr_oe_o(sdo_gyr_oe_o), .wr_valid_o(wr_valid_o), .wr_data_o(wr_data_o),
  .wr_ready_i(wr_ready_i), .spi_enabled_o(spi_enabled_o), .three_wire_o(three_wire_o),
  .write_gap_err_o(write_gap_err_o), .write_lost_o(write_lost_o));

// [sim/ssp_slave_port_tb.sv]
// Self-checking bench for the sensor SPI slave port
`timescale 1ns/1ps
module ssp_slave_port_tb;
  import ssp_pkg::*;
  logic        mclk = 1'b0;
  logic        rst  = 1'b0;
  logic        ps   = 1'b0;
  logic        susp = 1'b0;
  logic        rdy  = 1'b0;
  logic        sck, line, sd, sd_oe, am, am_oe, gyr, gyr_oe, wv, en, tw, cm, gerr, lost;
  logic [2:0]  sel_n;
  logic [1:0]  wu;
  logic [6:0]  wa;
  logic [7:0]  wd;
  logic [23:0] rd;
  int          fail_count  = 0;
  int          comparisons = 0;
  int          gap_seen    = 0;

  // Clock and gap pulse counter; the pulse lasts one cycle
  always #4 mclk = ~mclk;
  always @(posedge mclk) if (gerr) gap_seen++;

  ssp_slave_port #(.IDLE_SUS_CYC(300)) dut (.mclk_i(mclk), .sys_rst_i(rst),
    .protocol_select_pin_i(ps), .sck_i(sck), .sensor_select_n_i(sel_n),
    .shared_data_pin_i(line), .shared_data_pin_o(sd), .shared_data_pin_oe_o(sd_oe),
    .sdo_am_o(am), .sdo_am_oe_o(am_oe), .sdo_gyr_o(gyr), .sdo_gyr_oe_o(gyr_oe),
    .suspend_mode_i(susp), .wr_valid_o(wv), .wr_unit_o(wu), .wr_addr_o(wa),
    .wr_data_o(wd), .wr_ready_i(rdy), .spi_enabled_o(en), .three_wire_o(tw),
    .clock_mode_o(cm), .write_gap_err_o(gerr), .write_lost_o(lost));
  ssp_spi_master u_mst (.sck_o(sck), .sel_n_o(sel_n), .line_o(line), .sd_i(sd),
    .sd_oe_i(sd_oe), .am_i(am), .am_oe_i(am_oe), .gyr_i(gyr), .gyr_oe_i(gyr_oe),
    .three_i(tw));

  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic summarize();
    if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // Bounded wait for one buffered word, then take it
  task automatic pop(input logic [1:0] u, input logic [6:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge mclk);
    while (wv !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    if (wv !== 1'b1) begin
      chk("write wait", 24'h1, 24'h0);
      summarize();
    end
    chk("write word", {7'h0, wu, wa, wd}, {7'h0, u, a, d});
    rdy = 1'b1;
    @(negedge mclk) rdy = 1'b0;
  endtask : pop

  // Write, take the word, keep the normal idle gap
  task automatic wr(input logic [1:0] u, input logic m3, input logic [6:0] a,
                    input logic [7:0] d);
    u_mst.frame(u, m3, 1'b0, a, d, 1, rd);
    pop(u, a, d);
    #3000;
    chk("clock mode", {23'h0, cm}, {23'h0, m3});
  endtask : wr

  // Burst across the address wrap, mixed modes
  task automatic t_burst();
    wr(UNIT_ACC, 1'b1, 7'h7f, 8'ha5);
    wr(UNIT_ACC, 1'b0, 7'h00, 8'h5a);
    wr(UNIT_ACC, 1'b1, 7'h01, 8'h3c);
    u_mst.frame(UNIT_ACC, 1'b0, 1'b1, 7'h7f, 8'h00, 3, rd);
    chk("burst read", rd, 24'ha55a3c);
  endtask : t_burst

  // Gyro on its own output, magnetometer on the accel/mag output
  task automatic t_units();
    wr(UNIT_GYR, 1'b0, 7'h10, 8'hc3);
    wr(UNIT_MAG, 1'b1, 7'h10, 8'h96);
    u_mst.frame(UNIT_GYR, 1'b1, 1'b1, 7'h10, 8'h00, 1, rd);
    chk("gyro read", rd, 24'h0000c3);
    u_mst.frame(UNIT_MAG, 1'b0, 1'b1, 7'h10, 8'h00, 1, rd);
    chk("mag read", rd, 24'h000096);
  endtask : t_units

  // Consumer stalls: fill, drain in order, then overflow
  task automatic t_stall();
    for (int k = 0; k < 3; k++) begin
      u_mst.frame(k[1:0], 1'b1, 1'b0, 7'h20 + k[6:0], 8'h11 * k[7:0], 1, rd);
      #3000;
    end
    chk("no loss", {23'h0, lost}, 24'h0);
    for (int k = 0; k < 3; k++) pop(k[1:0], 7'h20 + k[6:0], 8'h11 * k[7:0]);
    for (int k = 0; k < 4; k++) begin
      u_mst.frame(UNIT_ACC, 1'b1, 1'b0, 7'h30, 8'h00, 1, rd);
      #3000;
    end
    chk("loss flag", {23'h0, lost}, 24'h1);
    @(negedge mclk) rdy = 1'b1;
    repeat (20) @(negedge mclk);
    rdy = 1'b0;
  endtask : t_stall

  // Back-to-back writes in suspend are flagged once
  task automatic t_gap();
    chk("no gap error", gap_seen, 0);
    @(negedge mclk) susp = 1'b1;
    u_mst.frame(UNIT_ACC, 1'b1, 1'b0, 7'h40, 8'h01, 1, rd);
    u_mst.frame(UNIT_ACC, 1'b1, 1'b0, 7'h41, 8'h02, 1, rd);
    pop(UNIT_ACC, 7'h40, 8'h01);
    pop(UNIT_ACC, 7'h41, 8'h02);
    chk("gap error", gap_seen, 1);
    susp = 1'b0;
    #3000;
  endtask : t_gap

  // 3-wire needs both select bits; read on the shared line
  task automatic t_three();
    wr(UNIT_ACC, 1'b1, THREE_WIRE_SELECT_ADDR, 8'h01);
    chk("one bit only", {23'h0, tw}, 24'h0);
    wr(UNIT_GYR, 1'b1, THREE_WIRE_SELECT_ADDR, 8'h01);
    chk("three wire", {23'h0, tw}, 24'h1);
    u_mst.frame(UNIT_ACC, 1'b1, 1'b1, 7'h7f, 8'h00, 1, rd);
    chk("shared read", rd, 24'h0000a5);
    wr(UNIT_GYR, 1'b1, THREE_WIRE_SELECT_ADDR, 8'h00);
    chk("back to four", {23'h0, tw}, 24'h0);
    chk("write release", u_mst.wr_drive, 24'h0);
  endtask : t_three

  // Strap high: frames are ignored
  task automatic t_strap();
    @(negedge mclk) ps = 1'b1;
    repeat (10) @(negedge mclk);
    chk("strap off", {23'h0, en}, 24'h0);
    u_mst.frame(UNIT_ACC, 1'b1, 1'b0, 7'h50, 8'h77, 1, rd);
    repeat (20) @(negedge mclk);
    chk("no commit", {23'h0, wv}, 24'h0);
    ps = 1'b0;
    repeat (10) @(negedge mclk);
    chk("strap on", {23'h0, en}, 24'h1);
  endtask : t_strap

  // Main sequence
  initial begin
    // Raised after time zero so the link-side flops see a reset edge
    #1 rst = 1'b1;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    repeat (12) @(negedge mclk);
    chk("reset state", {20'h0, en, tw, cm, wv}, 24'h8);
    t_burst();
    t_units();
    t_stall();
    t_gap();
    t_three();
    t_strap();
    summarize();
  end
endmodule : ssp_slave_port_tb

// [sim/ssp_spi_master.sv]
// SPI master partner model for the sensor slave port
`timescale 1ns/1ps
module ssp_spi_master (
  output logic       sck_o,
  output logic [2:0] sel_n_o,
  output logic       line_o,
  input  wire logic  sd_i,
  input  wire logic  sd_oe_i,
  input  wire logic  am_i,
  input  wire logic  am_oe_i,
  input  wire logic  gyr_i,
  input  wire logic  gyr_oe_i,
  input  wire logic  three_i
);
  logic drv_q = 1'b0;
  logic own_q = 1'b0;
  int   wr_drive = 0;
  initial sck_o = 1'b0;
  initial sel_n_o = 3'h7;

  // Released line shows the inverse of its last level, never a stale copy
  assign line_o = sd_oe_i ? sd_i : (own_q ? drv_q : ~drv_q);

  // Command byte then nb data bytes, MSB first; sck still between frames
  task automatic frame(input logic [1:0] u, input logic m3, input logic rw,
                       input logic [6:0] a, input logic [7:0] wd, input int nb,
                       output logic [23:0] rd);
    logic [7:0] cmd;
    logic       b;
    cmd = {rw, a};
    rd = 24'h0;
    sck_o = m3;
    #40 sel_n_o = ~(3'h1 << u);
    #40;
    for (int i = 0; i < 8 + 8 * nb; i++) begin
      sck_o = 1'b0;
      own_q = (i < 8) || !rw;
      drv_q = (i < 8) ? cmd[7 - i] : wd[7 - i % 8];
      #62.5 sck_o = 1'b1;
      b = three_i ? sd_i : ((u == 2'h1) ? gyr_i : am_i);
      if (!(three_i ? sd_oe_i : ((u == 2'h1) ? gyr_oe_i : am_oe_i))) b = 1'bx;
      if (i >= 8) rd = {rd[22:0], b};
      if (!rw && (sd_oe_i || am_oe_i || gyr_oe_i)) wr_drive++;
      #62.5;
    end
    sck_o = m3;
    #40 sel_n_o = 3'h7;
    own_q = 1'b0;
  endtask : frame
endmodule : ssp_spi_master
